/* File: hw/eod_pulse_divider.sv */
// Operation
// - two phases, 90 degrees apart, each with the programmed pulses per rev
// - exactly one index pulse on the third phase each revolution
// - each of the three phases is driven as a true/inverted pair
// - index pulse width equals one pulse of the first phase
// - reversed direction setting leaves the output phase form unchanged
// - divide encoder count by programmed count 16..262144, default 2048
// - accepted steps: 1,2,4,8,16 up to 16384,32768,65536,131072,262144
// - 13-bit takes up to 2048, 17-bit to 32768, 20-bit to 262144
// - setting alarm when count is out of range or off the grid
// - overspeed alarm above 6000 min-1 halving per band to 375
// - quadrature output rate stays below about 1.6 Mpps
`timescale 1ns/100ps
module eod_pulse_divider
	import eod_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        resetn_i,
	input  wire logic        enc_inc_i,
	input  wire logic        enc_dec_i,
	input  wire logic [2:0]  enc_res_i,
	input  wire logic [30:0] output_pulses_per_rev_i,
	input  wire logic        rotation_direction_select_i,
	input  wire logic [13:0] motor_speed_i,
	output logic             quad_out_a_o,
	output logic             quad_out_a_n_o,
	output logic             quad_out_b_o,
	output logic             quad_out_b_n_o,
	output logic             index_out_o,
	output logic             index_out_n_o,
	output logic             setting_err_o,
	output logic             overspeed_alarm_o
);

	localparam int GAP_LO = EDGE_GAP_CYC - 1;

	eod_div_st_t s_q;
	eod_div_st_t s_d;
	logic [30:0] cfg_ppr;
	logic [20:0] inc4;
	logic [20:0] top;
	logic [21:0] sum;
	logic [15:0] owed_n;
	logic        fwd;
	logic        bwd;
	logic        up;
	logic        dn;
	logic        range_ok;

	// a zero setting means the count was never programmed
	assign cfg_ppr = (output_pulses_per_rev_i == 31'h0) ?
		PPR_DEFAULT : output_pulses_per_rev_i;
	// four output edges per programmed pulse; fits since 4N never tops cpr
	assign inc4 = {s_q.ppr[18:0], 2'b00};
	assign top  = inc4 - 21'h1;

	// judges the same inputs that are captured, so the verdict lines up
	eod_range_check u_range (
		.core_clk_i (core_clk_i),
		.resetn_i   (resetn_i),
		.ppr_i      (cfg_ppr),
		.res_i      (enc_res_i),
		.ok_o       (range_ok)
	);

	// settings are sampled once after restart, checked, then run
	always_comb begin
		s_d      = s_q;
		s_d.step = 1'b0;
		sum      = 22'h0;
		owed_n   = s_q.owed;
		up       = 1'b0;
		dn       = 1'b0;
		fwd      = 1'b0;
		bwd      = 1'b0;
		if (!s_q.loaded) begin
			// later writes to the inputs wait for the next restart
			s_d.loaded  = 1'b1;
			s_d.rev_dir = rotation_direction_select_i;
			s_d.ppr     = cfg_ppr;
			case (enc_res_i)
				RES_13:  s_d.cpr = CPR_13;
				RES_17:  s_d.cpr = CPR_17;
				default: s_d.cpr = CPR_20;
			endcase
			// speed ceiling halves with each coarser band
			if (cfg_ppr <= PPR_BAND_1)
				s_d.spd_lim = SPD_LIM_1;
			else if (cfg_ppr <= PPR_BAND_2)
				s_d.spd_lim = SPD_LIM_2;
			else if (cfg_ppr <= PPR_BAND_4)
				s_d.spd_lim = SPD_LIM_4;
			else if (cfg_ppr <= PPR_BAND_8)
				s_d.spd_lim = SPD_LIM_8;
			else
				s_d.spd_lim = SPD_LIM_16;
		end else if (!s_q.armed) begin
			// a bad setting freezes the outputs until the next restart
			s_d.armed       = 1'b1;
			s_d.setting_err = !range_ok;
		end else if (!s_q.setting_err) begin
			// reversed mode swaps the count sense only; phase form is kept
			fwd = s_q.rev_dir ? (enc_dec_i & ~enc_inc_i)
				: (enc_inc_i & ~enc_dec_i);
			bwd = s_q.rev_dir ? (enc_inc_i & ~enc_dec_i)
				: (enc_dec_i & ~enc_inc_i);
			// remainder carries the fraction, so reversals retrace exactly
			if (fwd) begin
				sum = {1'b0, s_q.acc} + {1'b0, inc4};
				if (sum >= {1'b0, s_q.cpr}) begin
					s_d.acc = 21'(sum - {1'b0, s_q.cpr});
					up      = 1'b1;
				end else begin
					s_d.acc = sum[20:0];
				end
			end else if (bwd) begin
				if (s_q.acc >= inc4) begin
					s_d.acc = s_q.acc - inc4;
				end else begin
					s_d.acc = 21'(s_q.acc + s_q.cpr - inc4);
					dn      = 1'b1;
				end
			end
			// owed edges: +1 forward, -1 reverse
			owed_n = s_q.owed + {{15{dn}}, (up | dn)};
			// pacing caps the edge rate; bursts wait in the owed count
			if (s_q.gap != 8'h0) begin
				s_d.gap = s_q.gap - 8'h1;
			end else if (owed_n != 16'h0) begin
				s_d.step     = 1'b1;
				s_d.step_fwd = !owed_n[15];
				owed_n       = owed_n[15] ? owed_n + 16'h1 : owed_n - 16'h1;
				s_d.gap      = GAP_RELOAD;
			end
			s_d.owed = owed_n;
			// sticky until restart, so a brief excursion is not missed
			if (motor_speed_i > s_q.spd_lim)
				s_d.overspeed = 1'b1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i)
			s_q <= DIV_RST;
		else
			s_q <= s_d;
	end

	// phase and index drivers; a homing host should note the 600 min-1 limit
	eod_quad_gen u_quad (
		.core_clk_i (core_clk_i),
		.resetn_i   (resetn_i),
		.step_i     (s_q.step),
		.fwd_i      (s_q.step_fwd),
		.top_i      (top),
		.a_o        (quad_out_a_o),
		.a_n_o      (quad_out_a_n_o),
		.b_o        (quad_out_b_o),
		.b_n_o      (quad_out_b_n_o),
		.z_o        (index_out_o),
		.z_n_o      (index_out_n_o)
	);

	assign setting_err_o     = s_q.setting_err;
	assign overspeed_alarm_o = s_q.overspeed;

	property p_cfg_hold;
		@(posedge core_clk_i) disable iff (!resetn_i)
		s_q.loaded |=> $stable(s_q.ppr) && $stable(s_q.cpr);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold)
		else $error("setting changed without restart");

	property p_err_verdict;
		@(posedge core_clk_i) disable iff (!resetn_i)
		!s_q.armed ##1 s_q.armed |-> s_q.setting_err == !$past(range_ok);
	endproperty
	a_err_verdict: assert property (p_err_verdict)
		else $error("setting alarm disagrees with range check");

	property p_err_quiet;
		@(posedge core_clk_i) disable iff (!resetn_i)
		s_q.setting_err |-> !s_q.step && $stable(s_q.acc);
	endproperty
	a_err_quiet: assert property (p_err_quiet)
		else $error("outputs moved under a setting alarm");

	property p_res13_cap;
		@(posedge core_clk_i) disable iff (!resetn_i)
		s_q.armed && !s_q.setting_err && s_q.cpr == CPR_13
			|-> s_q.ppr <= PPR_TOP_13;
	endproperty
	a_res13_cap: assert property (p_res13_cap)
		else $error("13-bit encoder accepted too large a count");

	property p_grid;
		@(posedge core_clk_i) disable iff (!resetn_i)
		s_q.armed && !s_q.setting_err && s_q.ppr > PPR_BAND_1
			|-> s_q.ppr[0] == 1'b0;
	endproperty
	a_grid: assert property (p_grid)
		else $error("odd count accepted above the first band");

	property p_ovs_set;
		@(posedge core_clk_i) disable iff (!resetn_i)
		s_q.armed && !s_q.setting_err && motor_speed_i > s_q.spd_lim
			|=> s_q.overspeed;
	endproperty
	a_ovs_set: assert property (p_ovs_set)
		else $error("overspeed not flagged");

	property p_ovs_hold;
		@(posedge core_clk_i) disable iff (!resetn_i)
		s_q.overspeed |=> s_q.overspeed [*4];
	endproperty
	a_ovs_hold: assert property (p_ovs_hold)
		else $error("overspeed alarm dropped before restart");

	property p_rate;
		@(posedge core_clk_i) disable iff (!resetn_i)
		not (s_q.step ##[1:GAP_LO] s_q.step);
	endproperty
	a_rate: assert property (p_rate)
		else $error("output edges closer than the rate limit");

	property p_remainder;
		@(posedge core_clk_i) disable iff (!resetn_i)
		s_q.armed && !s_q.setting_err |-> s_q.acc < s_q.cpr;
	endproperty
	a_remainder: assert property (p_remainder)
		else $error("divider remainder out of range");

	property p_pairs;
		@(posedge core_clk_i) disable iff (!resetn_i)
		quad_out_a_o != quad_out_a_n_o && quad_out_b_o != quad_out_b_n_o
			&& index_out_o != index_out_n_o;
	endproperty
	a_pairs: assert property (p_pairs)
		else $error("output pair not complementary");

	property p_gray;
		@(posedge core_clk_i) disable iff (!resetn_i)
		$changed(quad_out_a_o) |-> $stable(quad_out_b_o);
	endproperty
	a_gray: assert property (p_gray)
		else $error("both phases changed together");

	property p_fwd_lead;
		@(posedge core_clk_i) disable iff (!resetn_i)
		s_q.step && s_q.step_fwd ##1 $rose(quad_out_a_o) |-> quad_out_b_o;
	endproperty
	a_fwd_lead: assert property (p_fwd_lead)
		else $error("second phase does not lead going forward");

	property p_rev_lag;
		@(posedge core_clk_i) disable iff (!resetn_i)
		s_q.step && !s_q.step_fwd ##1 $rose(quad_out_a_o) |-> !quad_out_b_o;
	endproperty
	a_rev_lag: assert property (p_rev_lag)
		else $error("second phase does not lag going reverse");

	property p_index_in_a;
		@(posedge core_clk_i) disable iff (!resetn_i)
		index_out_o |-> quad_out_a_o;
	endproperty
	a_index_in_a: assert property (p_index_in_a)
		else $error("index outside the first-phase high pulse");

	property p_index_edges;
		@(posedge core_clk_i) disable iff (!resetn_i)
		$changed(index_out_o) |-> $changed(quad_out_a_o);
	endproperty
	a_index_edges: assert property (p_index_edges)
		else $error("index edge not aligned with a first-phase edge");

endmodule : eod_pulse_divider

/* File: inc/eod_pkg.sv */
package eod_pkg;

	// core clock and the quadrature rate ceiling per phase
	localparam int unsigned CLK_HZ       = 250_000_000;
	localparam int unsigned QUAD_MAX_PPS = 1_600_000;
	// four output edges per pulse; a least spacing rounds up
	localparam int unsigned EDGE_GAP_CYC =
		(CLK_HZ + 4 * QUAD_MAX_PPS - 1) / (4 * QUAD_MAX_PPS);
	localparam logic [7:0]  GAP_RELOAD   = 8'(EDGE_GAP_CYC - 1);

	// pulses-per-revolution setting: floor, default, ceilings, step bands
	localparam logic [30:0] PPR_MIN      = 31'h10;
	localparam logic [30:0] PPR_DEFAULT  = 31'h800;
	localparam logic [30:0] PPR_TOP_13   = 31'h800;
	localparam logic [30:0] PPR_TOP_17   = 31'h8000;
	localparam logic [30:0] PPR_TOP_20   = 31'h4_0000;
	localparam logic [30:0] PPR_BAND_1   = 31'h4000;
	localparam logic [30:0] PPR_BAND_2   = 31'h8000;
	localparam logic [30:0] PPR_BAND_4   = 31'h1_0000;
	localparam logic [30:0] PPR_BAND_8   = 31'h2_0000;

	// encoder resolution codes and their counts per revolution
	localparam logic [2:0]  RES_13       = 3'h1;
	localparam logic [2:0]  RES_17       = 3'h2;
	localparam logic [2:0]  RES_20       = 3'h4;
	localparam logic [20:0] CPR_13       = 21'h2000;
	localparam logic [20:0] CPR_17       = 21'h2_0000;
	localparam logic [20:0] CPR_20       = 21'h10_0000;

	// motor speed ceilings in min-1, one per step band
	localparam logic [13:0] SPD_LIM_1    = 14'h1770;
	localparam logic [13:0] SPD_LIM_2    = 14'hbb8;
	localparam logic [13:0] SPD_LIM_4    = 14'h5dc;
	localparam logic [13:0] SPD_LIM_8    = 14'h2ee;
	localparam logic [13:0] SPD_LIM_16   = 14'h177;

	// quadrature phase states, one-hot
	typedef enum logic [3:0] {
		EOD_Q0 = 4'b0001,
		EOD_Q1 = 4'b0010,
		EOD_Q2 = 4'b0100,
		EOD_Q3 = 4'b1000
	} eod_qph_t;

	typedef struct packed {
		eod_qph_t    ph;
		logic [20:0] cnt;
		logic        a;
		logic        a_n;
		logic        b;
		logic        b_n;
		logic        z;
		logic        z_n;
	} eod_qg_st_t;

	localparam eod_qg_st_t QG_RST = '{ph: EOD_Q0, cnt: 21'h0,
		a: 1'b0, a_n: 1'b1, b: 1'b0, b_n: 1'b1, z: 1'b0, z_n: 1'b1};

	typedef struct packed {
		logic ok;
	} eod_rc_st_t;

	localparam eod_rc_st_t RC_RST = '{ok: 1'b0};

	typedef struct packed {
		logic        loaded;
		logic        armed;
		logic        rev_dir;
		logic [30:0] ppr;
		logic [20:0] cpr;
		logic [20:0] acc;
		logic [15:0] owed;
		logic [7:0]  gap;
		logic        step;
		logic        step_fwd;
		logic [13:0] spd_lim;
		logic        setting_err;
		logic        overspeed;
	} eod_div_st_t;

	localparam eod_div_st_t DIV_RST = '0;

endpackage : eod_pkg

/* File: hw/eod_range_check.sv */
`timescale 1ns/100ps
module eod_range_check
	import eod_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        resetn_i,
	input  wire logic [30:0] ppr_i,
	input  wire logic [2:0]  res_i,
	output logic             ok_o
);

	eod_rc_st_t  s_q;
	eod_rc_st_t  s_d;
	logic [30:0] top;
	logic        grid_ok;

	// ceiling by resolution, grid by band; an unknown code accepts nothing
	always_comb begin
		s_d = s_q;
		case (res_i)
			RES_13:  top = PPR_TOP_13;
			RES_17:  top = PPR_TOP_17;
			RES_20:  top = PPR_TOP_20;
			default: top = '0;
		endcase
		if (ppr_i <= PPR_BAND_1)
			grid_ok = 1'b1;
		else if (ppr_i <= PPR_BAND_2)
			grid_ok = (ppr_i[0] == 1'b0);
		else if (ppr_i <= PPR_BAND_4)
			grid_ok = (ppr_i[1:0] == 2'h0);
		else if (ppr_i <= PPR_BAND_8)
			grid_ok = (ppr_i[2:0] == 3'h0);
		else
			grid_ok = (ppr_i[3:0] == 4'h0);
		s_d.ok = (ppr_i >= PPR_MIN) && (ppr_i <= top) && grid_ok;
	end

	// verdict is registered; the caller samples it one cycle later
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i)
			s_q <= RC_RST;
		else
			s_q <= s_d;
	end

	assign ok_o = s_q.ok;

endmodule : eod_range_check

/* File: hw/eod_quad_gen.sv */
`timescale 1ns/100ps
module eod_quad_gen
	import eod_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        resetn_i,
	input  wire logic        step_i,
	input  wire logic        fwd_i,
	input  wire logic [20:0] top_i,
	output logic             a_o,
	output logic             a_n_o,
	output logic             b_o,
	output logic             b_n_o,
	output logic             z_o,
	output logic             z_n_o
);

	eod_qg_st_t s_q;
	eod_qg_st_t s_d;

	// one step moves one quarter period; position counts output edges
	always_comb begin
		s_d = s_q;
		if (step_i) begin
			if (fwd_i) begin
				s_d.cnt = (s_q.cnt >= top_i) ? 21'h0 : s_q.cnt + 21'h1;
				unique case (s_q.ph)
					EOD_Q0:  s_d.ph = EOD_Q1;
					EOD_Q1:  s_d.ph = EOD_Q2;
					EOD_Q2:  s_d.ph = EOD_Q3;
					EOD_Q3:  s_d.ph = EOD_Q0;
					default: s_d.ph = EOD_Q0;
				endcase
			end else begin
				s_d.cnt = (s_q.cnt == 21'h0) ? top_i : s_q.cnt - 21'h1;
				unique case (s_q.ph)
					EOD_Q0:  s_d.ph = EOD_Q3;
					EOD_Q1:  s_d.ph = EOD_Q0;
					EOD_Q2:  s_d.ph = EOD_Q1;
					EOD_Q3:  s_d.ph = EOD_Q2;
					default: s_d.ph = EOD_Q0;
				endcase
			end
		end
		// b rises a quarter period before a going forward
		s_d.a   = (s_d.ph == EOD_Q2) || (s_d.ph == EOD_Q3);
		s_d.b   = (s_d.ph == EOD_Q1) || (s_d.ph == EOD_Q2);
		// index sits on the first high half of a in each revolution
		s_d.z   = (s_d.cnt[20:2] == 19'h0) && s_d.cnt[1];
		s_d.a_n = ~s_d.a;
		s_d.b_n = ~s_d.b;
		s_d.z_n = ~s_d.z;
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i)
			s_q <= QG_RST;
		else
			s_q <= s_d;
	end

	assign a_o   = s_q.a;
	assign a_n_o = s_q.a_n;
	assign b_o   = s_q.b;
	assign b_n_o = s_q.b_n;
	assign z_o   = s_q.z;
	assign z_n_o = s_q.z_n;

endmodule : eod_quad_gen

/* File: testbench/eod_host_model.sv */
`timescale 1ns/100ps
// host controller side: decodes the quadrature feedback and counts origin
// pulses; any fault it sees is held in err_o until the next reset
module eod_host_model
	import eod_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	input  wire logic        a_i,
	input  wire logic        a_n_i,
	input  wire logic        b_i,
	input  wire logic        b_n_i,
	input  wire logic        z_i,
	input  wire logic        z_n_i,
	output logic      [31:0] pos_o,
	output logic      [15:0] idx_o,
	output logic             err_o
);
	logic [1:0] code;
	logic [1:0] prev_q;
	logic [7:0] gap_q;
	logic       seen_q;
	logic       z_q;

	// gray position: forward runs 00, 01, 11, 10 as (a, b)
	assign code = {a_i, a_i ^ b_i};

	// one step per sample at most; a jump of two states is a fault
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			pos_o  <= 32'h0;
			idx_o  <= 16'h0;
			err_o  <= 1'b0;
			prev_q <= 2'h0;
			gap_q  <= 8'h0;
			seen_q <= 1'b0;
			z_q    <= 1'b0;
		end else begin
			prev_q <= code;
			z_q    <= z_i;
			if (gap_q != 8'hff)
				gap_q <= gap_q + 8'h1;
			if (code != prev_q) begin
				gap_q  <= 8'h0;
				seen_q <= 1'b1;
				if (seen_q && gap_q < 8'(EDGE_GAP_CYC - 1))
					err_o <= 1'b1;
				if (2'(code - prev_q) == 2'h1)
					pos_o <= pos_o + 32'h1;
				else if (2'(code - prev_q) == 2'h3)
					pos_o <= pos_o - 32'h1;
				else
					err_o <= 1'b1;
			end
			if ({a_n_i, b_n_i, z_n_i} !== ~{a_i, b_i, z_i})
				err_o <= 1'b1;
			// origin pulse must sit inside one high pulse of phase a
			if (z_i && !a_i)
				err_o <= 1'b1;
			if (z_i && !z_q)
				idx_o <= idx_o + 16'h1;
		end
	end
endmodule : eod_host_model

/* File: testbench/encoder_pulse_output_divider_tb.sv */
`timescale 1ns/100ps
module encoder_pulse_output_divider_tb
	import eod_pkg::*;
;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic        inc = 1'b0;
	logic        dec = 1'b0;
	logic [2:0]  res = RES_13;
	logic [30:0] ppr = 31'h0;
	logic        rdir = 1'b0;
	logic [13:0] spd = 14'h0;
	logic        a, a_n, b, b_n, z, z_n, s_err, o_alm;
	logic [31:0] pos;
	logic [15:0] idx;
	logic        h_err;
	int          n_fail = 0;
	int          n_tests = 0;
	int          cyc = 0;
	int          k;
	logic [30:0] t_ppr [22] = '{31'h10, 31'hf, 31'h800, 31'h801, 31'h0,
		31'h4000, 31'h4001, 31'h4002, 31'h8000, 31'h8004, 31'h8002,
		31'h1_0008, 31'h1_0004, 31'h2_0010, 31'h2_0008, 31'h4_0000,
		31'h4_0010, 31'h61a8, 31'h61a9, 31'h8000, 31'h9c40, 31'h800};
	logic [2:0]  t_res [22] = '{1, 1, 1, 1, 1, 2, 2, 2, 2, 4, 4, 4, 4, 4,
		4, 4, 4, 4, 4, 1, 2, 3};
	logic [30:0] b_ppr [5] = '{31'h4000, 31'h8000, 31'h1_0000, 31'h2_0000,
		31'h4_0000};
	logic [13:0] b_lim [5] = '{14'h1770, 14'hbb8, 14'h5dc, 14'h2ee, 14'h177};

	always #2 clk = ~clk;

	eod_pulse_divider u_dut (
		.core_clk_i                  (clk),
		.resetn_i                    (resetn),
		.enc_inc_i                   (inc),
		.enc_dec_i                   (dec),
		.enc_res_i                   (res),
		.output_pulses_per_rev_i     (ppr),
		.rotation_direction_select_i (rdir),
		.motor_speed_i               (spd),
		.quad_out_a_o                (a),
		.quad_out_a_n_o              (a_n),
		.quad_out_b_o                (b),
		.quad_out_b_n_o              (b_n),
		.index_out_o                 (z),
		.index_out_n_o               (z_n),
		.setting_err_o               (s_err),
		.overspeed_alarm_o           (o_alm)
	);

	eod_host_model u_host (
		.clk_i    (clk),
		.resetn_i (resetn),
		.a_i      (a),
		.a_n_i    (a_n),
		.b_i      (b),
		.b_n_i    (b_n),
		.z_i      (z),
		.z_n_i    (z_n),
		.pos_o    (pos),
		.idx_o    (idx),
		.err_o    (h_err)
	);

	// expected acceptance of a setting; zero stands for the default count
	function automatic logic exp_ok(input logic [30:0] p, input logic [2:0] r);
		logic [30:0] n;
		logic [30:0] top;
		n = (p == 31'h0) ? PPR_DEFAULT : p;
		top = (r == RES_13) ? PPR_TOP_13 : (r == RES_17) ? PPR_TOP_17 :
			(r == RES_20) ? PPR_TOP_20 : 31'h0;
		if (n < PPR_MIN || n > top)
			return 1'b0;
		if (n > PPR_BAND_8)
			return n[3:0] == 4'h0;
		if (n > PPR_BAND_4)
			return n[2:0] == 3'h0;
		if (n > PPR_BAND_2)
			return n[1:0] == 2'h0;
		if (n > PPR_BAND_1)
			return n[0] == 1'b0;
		return 1'b1;
	endfunction : exp_ok

	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : report_and_stop

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// settings are held steady across the release so the capture edge sees them
	task automatic restart(input logic [30:0] p, input logic [2:0] r, input logic d);
		@(negedge clk);
		resetn = 1'b0;
		inc = 1'b0;
		dec = 1'b0;
		spd = 14'h0;
		ppr = p;
		res = r;
		rdir = d;
		repeat (16) @(negedge clk);
		resetn = 1'b1;
		repeat (3) @(negedge clk);
	endtask : restart

	// back-to-back encoder counts, one per cycle
	task automatic move(input int n, input logic fwd);
		repeat (n) begin
			inc = fwd;
			dec = !fwd;
			@(negedge clk);
		end
		inc = 1'b0;
		dec = 1'b0;
	endtask : move

	// bounded wait for the paced output edges to drain
	task automatic wait_pos(input logic [31:0] e, input int lim);
		int i;
		for (i = 0; i < lim && pos !== e; i++)
			@(negedge clk);
		repeat (100) @(negedge clk);
	endtask : wait_pos

	// hang guard well above the planned run length
	always @(posedge clk) begin
		cyc++;
		if (cyc == 100000) begin
			n_fail++;
			report_and_stop();
		end
	end

	initial begin
		k = $urandom(32'hcc7d7b9f);
		for (int i = 0; i < 22; i++) begin
			restart(t_ppr[i], t_res[i], 1'b0);
			chk("setting_err", {31'h0, !exp_ok(t_ppr[i], t_res[i])}, {31'h0, s_err});
		end
		for (int i = 0; i < 6; i++) begin
			restart(31'($urandom_range(300000)), 3'(1 << $urandom_range(2)), 1'b0);
			chk("rnd setting_err", {31'h0, !exp_ok(ppr, res)}, {31'h0, s_err});
		end
		// one full turn at 16 pulses per rev, slow enough for homing
		restart(31'h10, RES_13, 1'b0);
		move(8192, 1'b1);
		wait_pos(32'd64, 4000);
		chk("edges per rev", 32'd64, pos);
		chk("index per rev", 32'd1, {16'h0, idx});
		move(8192, 1'b0);
		wait_pos(32'd0, 4000);
		chk("edges back", 32'd0, pos);
		chk("host faults", 32'd0, {31'h0, h_err});
		restart(31'h0, RES_13, 1'b0);
		k = $urandom_range(200, 1);
		move(k, 1'b1);
		wait_pos(32'(k), 12000);
		chk("default count edges", 32'(k), pos);
		restart(31'h800, RES_13, 1'b1);
		move(50, 1'b1);
		wait_pos(-32'sd50, 3000);
		chk("reversed edges", -32'sd50, pos);
		chk("reversed faults", 32'd0, {31'h0, h_err});
		for (int i = 0; i < 5; i++) begin
			restart(b_ppr[i], RES_20, 1'b0);
			spd = b_lim[i];
			repeat (6) @(negedge clk);
			chk("alarm at limit", 32'd0, {31'h0, o_alm});
			spd = b_lim[i] + 14'h1;
			repeat (3) @(negedge clk);
			chk("alarm over limit", 32'd1, {31'h0, o_alm});
			spd = 14'h0;
			repeat (3) @(negedge clk);
			chk("alarm sticky", 32'd1, {31'h0, o_alm});
		end
		report_and_stop();
	end
endmodule : encoder_pulse_output_divider_tb
